/* verilog/rff_rx_port.sv */
// rmii receive port with frame filter, backpressure and axi4-lite registers
// Notes on behaviour
// - carrier sense starts the receive state
// - data arrives as di-bits on reference clock
// - hunt for delimiter 10101011, drop preamble
// - bytes after the delimiter go to buffer
// - frames under 64 or over 1536 dropped
// - bytes beyond 1536 are not stored
// - half-duplex overlong frame blocks tx and rx
// - errored frames are never forwarded
// - destination equal to own port is dropped
// - disabled receiving port drops its frames
// - buffer full discards the incoming frame
// - flow control throttles sender while buffer full
// - security violation dropped when security enabled
// - verdict uses routing, vlan, port state, config
// - tx di-bits launched on reference rising edge
// - rx di-bits captured on reference rising edge
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
module rff_rx_port
  import rff_pkg::*;
#(
  parameter logic [2:0] PORT_ID = 3'h5
)
(
  // system
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  // rmii pins
  input  wire logic        shared_rmii_ref_clock_i,
  input  wire logic        port5_carrier_sense_i,
  input  wire logic        port5_rx_dibit_hi_i,
  input  wire logic        port5_rx_dibit_lo_i,
  input  wire logic        port5_rx_symbol_err_i,
  output logic             port5_tx_enable_o,
  output logic             port5_tx_dibit_hi_o,
  output logic             port5_tx_dibit_lo_o,
  // frame buffer and lookup
  input  wire logic        buffer_full_i,
  input  wire logic [2:0]  lookup_dest_port_i,
  input  wire logic        lookup_vlan_ok_i,
  input  wire logic        lookup_sec_viol_i,
  output logic [7:0]       buf_data_o,
  output logic             buf_valid_o,
  output logic             buf_sof_o,
  output logic             frame_done_o,
  output logic             frame_accept_o,
  output logic             pause_request_o,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt
  output logic             irq_o
);

  // ****************************************
  // pin synchronisers and reference edge
  // ****************************************
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic       ref_d_reg;
  logic       ref_rise;

  // every pin passes two flops; the first is read only by the second
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_reg  <= 5'h00;
      sync_reg  <= 5'h00;
      ref_d_reg <= 1'b0;
    end
    else
    begin
      meta_reg  <= {port5_rx_symbol_err_i, port5_rx_dibit_hi_i, port5_rx_dibit_lo_i,
                    port5_carrier_sense_i, shared_rmii_ref_clock_i};
      sync_reg  <= meta_reg;
      ref_d_reg <= sync_reg[0];
    end
  end

  // data and clock share the same latency, so sampling at the edge stays aligned
  assign ref_rise = sync_reg[0] & ~ref_d_reg;

  logic       crs;
  logic [1:0] dibit;
  logic       sym_err;
  assign crs     = sync_reg[1];
  assign dibit   = sync_reg[3:2];
  assign sym_err = sync_reg[4];

  // ****************************************
  // registers
  // ****************************************
  logic [3:0]      ctrl_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] mask_reg;
  logic [ST_W-1:0] event_set;
  logic [10:0]     last_len_reg;
  logic [15:0]     good_cnt_reg;

  // ****************************************
  // receive state machine
  // ****************************************
  rff_rx_state_t state_reg;
  logic [7:0]    shift_reg;
  logic [1:0]    phase_reg;
  logic [10:0]   len_reg;
  logic [31:0]   crc_reg;
  logic          sym_seen_reg;
  logic          full_seen_reg;
  logic          end_frame;
  logic [7:0]    new_byte;

  // byte-wise reflected crc
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction

  assign new_byte  = {dibit, shift_reg[7:2]};
  assign end_frame = ref_rise & ~crs & (state_reg == RX_DATA);

  // frame reception at each reference rising edge
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg     <= RX_IDLE;
      shift_reg     <= 8'h00;
      phase_reg     <= 2'h0;
      len_reg       <= 11'h000;
      crc_reg       <= CRC_INIT;
      sym_seen_reg  <= 1'b0;
      full_seen_reg <= 1'b0;
    end
    else if (ref_rise)
    begin
      shift_reg <= new_byte;
      case (state_reg)
        RX_IDLE:
        begin
          if (crs)
          begin
            state_reg     <= RX_HUNT;
            sym_seen_reg  <= 1'b0;
            full_seen_reg <= 1'b0;
          end
        end
        RX_HUNT:
        begin
          if (!crs)
            state_reg <= RX_IDLE;
          else if (new_byte == SFD_BYTE)
          begin
            state_reg <= RX_DATA;
            phase_reg <= 2'h0;
            len_reg   <= 11'h000;
            crc_reg   <= CRC_INIT;
          end
        end
        RX_DATA:
        begin
          if (!crs)
            state_reg <= RX_IDLE;
          else
          begin
            phase_reg <= phase_reg + 2'h1;
            if (sym_err)
              sym_seen_reg <= 1'b1;
            if (phase_reg == 2'h3)
            begin
              crc_reg <= crc_byte(crc_reg, new_byte);
              if (len_reg <= LEN_MAX)
                len_reg <= len_reg + 11'h001; // saturates one past the limit
              if (buffer_full_i)
                full_seen_reg <= 1'b1;
              if (len_reg >= LEN_MAX && ctrl_reg[CTRL_HALF_DPX])
                state_reg <= RX_LOCK;
            end
          end
        end
        RX_LOCK:
        begin
          // nothing is taken or sent until the carrier goes away
          if (!crs)
            state_reg <= RX_IDLE;
        end
        default:
          state_reg <= RX_IDLE;
      endcase
    end
  end

  // buffer write: one pulse per byte, never beyond the length limit
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      buf_data_o  <= 8'h00;
      buf_valid_o <= 1'b0;
      buf_sof_o   <= 1'b0;
    end
    else
    begin
      buf_valid_o <= 1'b0;
      buf_sof_o   <= 1'b0;
      if (ref_rise && crs && state_reg == RX_DATA && phase_reg == 2'h3 &&
          len_reg < LEN_MAX && !buffer_full_i)
      begin
        buf_data_o  <= new_byte;
        buf_valid_o <= 1'b1;
        buf_sof_o   <= (len_reg == 11'h000);
      end
    end
  end

  // ****************************************
  // frame verdict
  // ****************************************
  logic len_bad;
  logic crc_bad;
  logic sym_bad;
  logic err_any;
  logic filt;
  logic sec_drop;
  logic accept;

  assign len_bad  = (len_reg < LEN_MIN) || (len_reg > LEN_MAX);
  assign crc_bad  = (crc_reg != CRC_RESIDUE);
  assign sym_bad  = sym_seen_reg || (phase_reg != 2'h0); // dribble counts as symbol error
  assign err_any  = len_bad | crc_bad | sym_bad;
  assign filt     = !ctrl_reg[CTRL_PORT_EN] || (lookup_dest_port_i == PORT_ID) ||
                    !lookup_vlan_ok_i;
  assign sec_drop = ctrl_reg[CTRL_SEC_EN] & lookup_sec_viol_i;
  assign accept   = !err_any && !filt && !sec_drop && !full_seen_reg;

  // the verdict is taken when the carrier falls in the data state
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      frame_done_o   <= 1'b0;
      frame_accept_o <= 1'b0;
      last_len_reg   <= 11'h000;
      good_cnt_reg   <= 16'h0000;
    end
    else
    begin
      frame_done_o <= end_frame;
      if (end_frame)
      begin
        frame_accept_o <= accept;
        last_len_reg   <= len_reg;
        if (accept)
          good_cnt_reg <= good_cnt_reg + 16'h0001;
      end
    end
  end

  always_comb
  begin
    event_set             = '0;
    event_set[ST_OK]      = end_frame & accept;
    event_set[ST_LEN_ERR] = end_frame & len_bad;
    event_set[ST_CRC_ERR] = end_frame & crc_bad;
    event_set[ST_SYM_ERR] = end_frame & sym_bad;
    event_set[ST_FILTER]  = end_frame & filt;
    event_set[ST_FULL]    = end_frame & full_seen_reg;
    event_set[ST_SECURE]  = end_frame & sec_drop;
  end

  // ****************************************
  // backpressure transmit
  // ****************************************
  logic jam_req;
  assign jam_req = ctrl_reg[CTRL_FLOW_EN] & ctrl_reg[CTRL_HALF_DPX] & buffer_full_i &
                   (state_reg != RX_LOCK);

  // jam launched on the reference rising edge; full duplex asks for pause instead
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      port5_tx_enable_o   <= 1'b0;
      port5_tx_dibit_hi_o <= 1'b0;
      port5_tx_dibit_lo_o <= 1'b0;
      pause_request_o     <= 1'b0;
    end
    else
    begin
      pause_request_o <= ctrl_reg[CTRL_FLOW_EN] & ~ctrl_reg[CTRL_HALF_DPX] &
                         buffer_full_i;
      if (ref_rise)
      begin
        port5_tx_enable_o   <= jam_req;
        port5_tx_dibit_hi_o <= jam_req & JAM_DIBIT[1];
        port5_tx_dibit_lo_o <= jam_req & JAM_DIBIT[0];
      end
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic        wr_go;
  logic        wr_hit;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign wr_go  = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign wr_hit = (aw_addr_reg == ADDR_CTRL) || (aw_addr_reg == ADDR_STATUS) ||
                  (aw_addr_reg == ADDR_MASK);

  // address and data are taken in either order, one write at a time
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
      end
      if (wr_go)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // control and mask live in byte lane 0; status bits clear on writing one
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_reg   <= CTRL_RESET;
      mask_reg   <= '0;
      status_reg <= '0;
    end
    else
    begin
      if (wr_go && w_strb_reg[0] && aw_addr_reg == ADDR_CTRL)
        ctrl_reg <= w_data_reg[3:0];
      if (wr_go && w_strb_reg[0] && aw_addr_reg == ADDR_MASK)
        mask_reg <= w_data_reg[ST_W-1:0];
      // a new event wins over a clear in the same cycle
      if (wr_go && w_strb_reg[0] && aw_addr_reg == ADDR_STATUS)
        status_reg <= (status_reg & ~w_data_reg[ST_W-1:0]) | event_set;
      else
        status_reg <= status_reg | event_set;
    end
  end

  always_comb
  begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL:   rd_val[3:0] = ctrl_reg;
      ADDR_STATUS: rd_val[ST_W-1:0] = status_reg;
      ADDR_MASK:   rd_val[ST_W-1:0] = mask_reg;
      ADDR_LAST:
      begin
        rd_val[10:0]      = last_len_reg;
        rd_val[LAST_BUSY] = (state_reg != RX_IDLE);
      end
      ADDR_GOOD:   rd_val[15:0] = good_cnt_reg;
      default:     rd_hit = 1'b0;
    endcase
  end

  // reads answer the cycle after the address is taken
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // level interrupt while any unmasked status bit is set
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(status_reg & mask_reg);
  end

endmodule

/* verilog/rff_pkg.sv */
// constants shared by the rmii receive frame filter
package rff_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_LAST   = 8'h0C;
  localparam logic [7:0] ADDR_GOOD   = 8'h10;

  // control fields
  localparam int CTRL_PORT_EN  = 0;
  localparam int CTRL_HALF_DPX = 1;
  localparam int CTRL_FLOW_EN  = 2;
  localparam int CTRL_SEC_EN   = 3;
  localparam logic [3:0] CTRL_RESET = 4'h1;

  // status / mask fields
  localparam int ST_OK      = 0;
  localparam int ST_LEN_ERR = 1;
  localparam int ST_CRC_ERR = 2;
  localparam int ST_SYM_ERR = 3;
  localparam int ST_FILTER  = 4;
  localparam int ST_FULL    = 5;
  localparam int ST_SECURE  = 6;
  localparam int ST_W       = 7;
  localparam int LAST_BUSY  = 16;

  // frame format
  localparam logic [7:0]  SFD_BYTE    = 8'hD5;  // 10101011, first bit in lsb
  localparam logic [10:0] LEN_MIN     = 11'h040;
  localparam logic [10:0] LEN_MAX     = 11'h600;
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  localparam logic [1:0]  JAM_DIBIT   = 2'h1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_DATA, RX_LOCK} rff_rx_state_t;

endpackage

/* tb/rff_rx_monitor.sv */
// assertion checker bound to the rmii receive port
module rff_rx_monitor
  import rff_pkg::*;
(
  // clock, reset and watched ports
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic shared_rmii_ref_clock_i,
  input wire logic buffer_full_i,
  input wire logic buf_valid_o,
  input wire logic buf_sof_o,
  input wire logic frame_done_o,
  input wire logic frame_accept_o,
  input wire logic pause_request_o,
  input wire logic port5_tx_enable_o,
  input wire logic port5_tx_dibit_hi_o,
  input wire logic port5_tx_dibit_lo_o,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************
  // properties
  // ************
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  // read accepted, then answered on the next cycle
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_answer;
    ##1 s_axi_rvalid;
  endsequence

  chk_read_answer: assert property (rd_taken |-> rd_answer)
    else $error("read answer late");
  chk_sof_with_byte: assert property (buf_sof_o |-> buf_valid_o)
    else $error("start marker without byte");
  // a byte takes four di-bits of eight system cycles each
  chk_byte_spacing: assert property (buf_valid_o |=> !buf_valid_o [*8])
    else $error("bytes too close");
  chk_done_pulse: assert property (frame_done_o |=> !frame_done_o)
    else $error("frame end pulse too long");
  chk_verdict_moves: assert property ($changed(frame_accept_o) |-> frame_done_o)
    else $error("verdict moved outside frame end");
  chk_pause_cause: assert property (pause_request_o |-> $past(buffer_full_i))
    else $error("pause without full buffer");
  chk_jam_dibit: assert property
    ({port5_tx_dibit_hi_o, port5_tx_dibit_lo_o} == (port5_tx_enable_o ? JAM_DIBIT : 2'h0))
    else $error("wrong transmit di-bit");
  // sync and edge finding put the reference rise three cycles back
  chk_tx_on_ref: assert property ($changed(port5_tx_enable_o) |->
    $past(shared_rmii_ref_clock_i, 3) && !$past(shared_rmii_ref_clock_i, 7))
    else $error("transmit enable off reference edge");
endmodule

bind rff_rx_port rff_rx_monitor i_mon (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .buffer_full_i(buffer_full_i),
  .shared_rmii_ref_clock_i(shared_rmii_ref_clock_i), .buf_valid_o(buf_valid_o),
  .buf_sof_o(buf_sof_o), .frame_done_o(frame_done_o), .frame_accept_o(frame_accept_o),
  .pause_request_o(pause_request_o), .port5_tx_enable_o(port5_tx_enable_o),
  .port5_tx_dibit_hi_o(port5_tx_dibit_hi_o), .port5_tx_dibit_lo_o(port5_tx_dibit_lo_o),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);

/* tb/rff_phy_model.sv */
// behavioural rmii phy that sends frames into the receive port
module rff_phy_model
  import rff_pkg::*;
(
  // rmii pins toward the port
  output logic ref_clk_o,
  output logic crs_o,
  output logic rxd_hi_o,
  output logic rxd_lo_o,
  output logic sym_err_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // *****************
  // frame generator
  // *****************
  logic [7:0] sent [$];

  initial {ref_clk_o, crs_o, rxd_hi_o, rxd_lo_o, sym_err_o} = 5'h0;
  // free-running shared reference for all ports, so jam can end between frames
  always #100 ref_clk_o = ~ref_clk_o;

  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] x;
    x = c ^ {24'h0, b};
    for (int j = 0; j < 8; j++)
      x = x[0] ? (x >> 1) ^ CRC_POLY : x >> 1;
    return x;
  endfunction

  // change on the falling edge so the port samples settled di-bits
  task automatic put(input logic [7:0] b, input logic e);
    for (int k = 0; k < 4; k++)
    begin
      @(negedge ref_clk_o);
      {rxd_hi_o, rxd_lo_o} = b[2*k +: 2];
      sym_err_o = e;
    end
  endtask

  // preamble of random length, delimiter, payload, fcs; bad flips one fcs bit
  task automatic send(input int len, input logic bad, input int e, input logic sfd);
    logic [31:0] c;
    logic [7:0]  b;
    c = CRC_INIT;
    sent.delete();
    // carrier rises off the system clock edge, one reference period ahead of data
    @(negedge ref_clk_o);
    crs_o = 1'b1;
    repeat (1 + $urandom % 7)
      put(8'h55, 1'b0);
    if (!sfd)
      repeat (len)
        put(8'h55, 1'b0);
    else
    begin
      put(SFD_BYTE, 1'b0);
      for (int i = 0; i < len - 4; i++)
      begin
        b = 8'($urandom);
        c = crc8(c, b);
        put(b, i == e);
        sent.push_back(b);
      end
      c = ~c ^ {31'h0, bad};
      repeat (4)
      begin
        put(c[7:0], 1'b0);
        sent.push_back(c[7:0]);
        c = c >> 8;
      end
    end
    @(negedge ref_clk_o);
    crs_o = 1'b0;
    {rxd_hi_o, rxd_lo_o} = ~{rxd_hi_o, rxd_lo_o};  // released lines show the inverse
    sym_err_o = 1'b0;
    repeat (4)
      @(negedge ref_clk_o);
  endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the rmii receive port and its phy model
module tb
  import rff_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // *********
  // harness
  // *********
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        full = 1'b0, vlan_ok = 1'b1, viol = 1'b0;
  logic [2:0]  dest = 3'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        ref_clk, crs, rx_hi, rx_lo, sym, tx_en, tx_hi, tx_lo, irq;
  logic        awready, wready, bvalid, arready, rvalid, buf_valid, buf_sof, done, accept, pause;
  logic [7:0]  buf_data;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  got [$];
  logic [7:0]  adr [5] = '{ADDR_CTRL, ADDR_STATUS, ADDR_MASK, ADDR_LAST, ADDR_GOOD};
  int          n_fail = 0, checks = 0, cyc = 0, n_done = 0, jam = 0, n_good = 0, sof_at = -1;

  always #12.5 clk_sys_i = ~clk_sys_i;

  rff_phy_model i_rff_phy_model (.ref_clk_o(ref_clk), .crs_o(crs), .rxd_hi_o(rx_hi),
    .rxd_lo_o(rx_lo), .sym_err_o(sym));
  rff_rx_port i_rff_rx_port (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .shared_rmii_ref_clock_i(ref_clk), .port5_carrier_sense_i(crs), .port5_rx_dibit_hi_i(rx_hi),
    .port5_rx_dibit_lo_i(rx_lo), .port5_rx_symbol_err_i(sym), .port5_tx_enable_o(tx_en),
    .port5_tx_dibit_hi_o(tx_hi), .port5_tx_dibit_lo_o(tx_lo), .buffer_full_i(full),
    .lookup_dest_port_i(dest), .lookup_vlan_ok_i(vlan_ok), .lookup_sec_viol_i(viol),
    .buf_data_o(buf_data), .buf_valid_o(buf_valid), .buf_sof_o(buf_sof), .frame_done_o(done),
    .frame_accept_o(accept), .pause_request_o(pause), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq_o(irq));

  // stored bytes, frame ends, jam cycles and the hang limit
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (buf_sof === 1'b1) sof_at = got.size();
    if (buf_valid === 1'b1) got.push_back(buf_data);
    if (done === 1'b1) n_done++;
    if (tx_en === 1'b1) jam++;
    if (cyc == 100000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [33:0] g, input logic [33:0] x, input string m);
    checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, x);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // axi4-lite write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge clk_sys_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge clk_sys_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // expected status bits; the port under test is number 5
  function automatic logic [6:0] exp_st(input int len, input logic bad, input int e,
                                        input logic [3:0] c);
    logic [6:0] s;
    s = 7'h0;
    s[ST_LEN_ERR] = len < LEN_MIN || len > LEN_MAX;
    s[ST_CRC_ERR] = bad;
    s[ST_SYM_ERR] = e >= 0;
    s[ST_FILTER] = !c[CTRL_PORT_EN] || dest == 3'h5 || !vlan_ok;
    s[ST_FULL] = full;
    s[ST_SECURE] = c[CTRL_SEC_EN] && viol;
    s[ST_OK] = s == 7'h0;
    return s;
  endfunction

  task automatic frame(input int len, input logic bad, input int e, input logic [3:0] c);
    int          d0;
    logic [6:0]  s;
    logic [31:0] v;
    logic [1:0]  r;
    wr(ADDR_CTRL, {28'h0, c}, r);
    wr(ADDR_STATUS, 32'h7F, r);
    s = exp_st(len, bad, e, c);
    d0 = n_done;
    got.delete();
    sof_at = -1;
    i_rff_phy_model.send(len, bad, e, 1'b1);
    for (int i = 0; i < 40 && n_done == d0; i++)
      @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    chk(n_done - d0, (c[CTRL_HALF_DPX] && len > LEN_MAX) ? 0 : 1, "frame ends");
    chk(got.size(), full ? 0 : (len > LEN_MAX ? LEN_MAX : len), "stored");
    foreach (got[i]) chk(got[i], i_rff_phy_model.sent[i], "byte");
    chk(sof_at, got.size() > 0 ? 0 : -1, "first byte marked");
    if (n_done == d0) return;
    rd(ADDR_STATUS, v, r);
    chk(v, {25'h0, s}, "status");
    chk(accept, s[ST_OK], "verdict");
    rd(ADDR_LAST, v, r);
    chk(v[LAST_BUSY:0], len, "length and idle");
    n_good += s[ST_OK];
  endtask

  initial
  begin
    logic [31:0] v;
    logic [1:0]  r;
    void'($urandom(32'hF9CA0CB7));
    repeat (4) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    foreach (adr[i])
    begin
      rd(adr[i], v, r);
      chk(v, i == 0 ? 32'h1 : 32'h0, "reset value");
    end
    rd(8'h20, v, r);
    chk({r, v}, {RESP_SLVERR, 32'h0}, "unmapped read");
    wr(8'h20, 32'hFFFFFFFF, r);
    chk(r, RESP_SLVERR, "unmapped write");
    $display("test registers done");
    repeat (2) frame(LEN_MIN + $urandom % 16, 1'b0, -1, 4'h1);
    frame(LEN_MIN - 1, 1'b0, -1, 4'h1);
    frame(LEN_MIN, 1'b1, -1, 4'h1);
    frame(LEN_MIN + 8, 1'b0, 12, 4'h1);
    $display("test lengths and errors done");
    // own port, disabled port, vlan, violation unsecured then secured
    for (int i = 0; i < 5; i++)
    begin
      dest <= i == 0 ? 3'h5 : 3'h1;
      vlan_ok <= i != 2;
      viol <= i > 2;
      frame(LEN_MIN, 1'b0, -1, i == 1 ? 4'h0 : (i == 4 ? 4'h9 : 4'h1));
    end
    viol <= 1'b0;
    full <= 1'b1;
    frame(LEN_MIN, 1'b0, -1, 4'h5);
    chk(pause, 1'b1, "pause");
    jam = 0;
    frame(LEN_MIN, 1'b0, -1, 4'h7);
    chk(jam > 0, 1'b1, "jam");
    full <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    chk(tx_en, 1'b0, "jam released");
    $display("test filters and flow done");
    wr(ADDR_MASK, 32'h1, r);
    frame(LEN_MIN, 1'b0, -1, 4'h1);
    chk(irq, 1'b1, "irq raised");
    wr(ADDR_STATUS, 32'h1, r);
    repeat (2) @(posedge clk_sys_i);
    chk(irq, 1'b0, "irq cleared");
    wr(ADDR_MASK, 32'h0, r);
    frame(LEN_MIN, 1'b0, -1, 4'h1);
    chk(irq, 1'b0, "irq masked");
    $display("test interrupt done");
    v = n_done;
    i_rff_phy_model.send(LEN_MIN, 1'b0, -1, 1'b0);
    repeat (40) @(posedge clk_sys_i);
    chk(n_done, v, "no delimiter");
    frame(LEN_MAX + 1, 1'b0, -1, 4'h3);
    rd(ADDR_GOOD, v, r);
    chk(v, n_good, "good count");
    $display("test hunt and overlong done");
    tally_and_finish();
  end
endmodule
